/* File: rtl/cts_top.sv */
// top: receive FIFO overflow flags, time stamp timer and register port
//
// the time stamp counter advances on prescaler ticks while capture is
// enabled; the overflow flags are set by the FIFO logic and cleared by it.

// Notes on behaviour
// - sixteen sticky per-FIFO overflow flags, readable
// - overflow register upper sixteen bits read zero
// - free-running count advances on each prescaler period
// - prescale all ones gives one step per 65535
// - prescale zero gives one step per clock
// - capture disabled holds counter and prescaler
// - timer write restarts prescaler, loads prescale field
// - timer register: count high, prescale low, RW
// - overflow source reports its own interrupt code
// - timer source reports its own interrupt code
module cts_top
  import cts_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input cts_pkg::cts_addr_t addr,
  input cts_pkg::cts_data_t wdata,
  input wire logic wr,
  input wire logic rd,
  output cts_pkg::cts_data_t rdata,
  input cts_pkg::cts_fifo_t fifo_overflow_set,
  input cts_pkg::cts_fifo_t fifo_overflow_clear,
  output cts_pkg::cts_fifo_t fifo_overflow_flags,
  output logic timestamp_capture_enable,
  output cts_pkg::cts_cnt_t timestamp_count,
  output logic rx_overflow_event,
  output logic timestamp_timer_event,
  output cts_pkg::cts_code_t interrupt_code_field
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    cts_fifo_t ovf;
    cts_cnt_t count;
    cts_cnt_t prescale;
    logic cap_en;
    logic tmr_evt;
    cts_code_t code;
    cts_data_t rdata;
  } cts_state_t;

  localparam cts_state_t CTS_STATE_RST = '{
    ovf: CTS_OVF_RST,
    count: CTS_CNT_RST,
    prescale: CTS_CNT_RST,
    cap_en: 1'b0,
    tmr_evt: 1'b0,
    code: CTS_CODE_NONE,
    rdata: CTS_DATA_ZERO
  };

  cts_state_t st_q;
  cts_state_t st_d;

  cts_tick_if tk ();
  cts_code_t code_c;
  logic wr_ovf;
  logic wr_tmr;
  logic wr_ctrl;
  logic wr_evt;
  logic wrap;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // field extraction of a 16-bit half of a bus word
  function automatic cts_cnt_t half_of(input cts_data_t w, input int unsigned lsb);
    half_of = w[lsb +: CTS_CNT_W];
  endfunction : half_of

  // address match against a register address on a strobe
  function automatic logic hit(input logic strobe, input cts_addr_t a, input cts_addr_t reg_addr);
    hit = strobe && (a == reg_addr);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////////
  // write decode

  assign wr_ovf = hit(wr, addr, CTS_OVF_ADDR);
  assign wr_tmr = hit(wr, addr, CTS_TMR_ADDR);
  assign wr_ctrl = hit(wr, addr, CTS_CTRL_ADDR);
  assign wr_evt = hit(wr, addr, CTS_EVT_ADDR);

  ////////////////////////////////////////////////////////////////////////////////
  // prescaler

  // prescaler runs from the stored field, restarted by any timer write
  assign tk.prescale = st_q.prescale;
  assign tk.enable = st_q.cap_en;
  assign tk.restart = wr_tmr;

  cts_prescaler u_presc (
    .clock(clock),
    .rst(rst),
    .tk(tk.presc)
  );

  // counter reaches its top and steps again
  assign wrap = tk.tick && (st_q.count == CTS_CNT_MAX);

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt code

  cts_interrupt_code_field u_interrupt_code_field (
    .ovf_pending(|st_q.ovf),
    .tmr_pending(st_q.tmr_evt),
    .code(code_c)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d = st_q;

    // overflow flags: FIFO logic sets and clears, set wins
    st_d.ovf = (st_q.ovf & ~fifo_overflow_clear) | fifo_overflow_set;

    // capture enable control bit
    if (wr_ctrl) begin
      st_d.cap_en = wdata[CTS_CTRL_CAP_BIT];
    end

    // time stamp counter: a write loads both halves, else count on tick
    if (wr_tmr) begin
      st_d.count = half_of(wdata, CTS_TMR_COUNT_LSB);
      st_d.prescale = half_of(wdata, CTS_TMR_PRE_LSB);
    end else if (tk.tick) begin
      st_d.count = st_q.count + CTS_CNT_ONE;
    end

    // timer event: write one to clear, a new wrap wins
    if (wr_evt && wdata[CTS_EVT_TMR_BIT]) begin
      st_d.tmr_evt = 1'b0;
    end
    if (wrap) begin
      st_d.tmr_evt = 1'b1;
    end

    // interrupt code follows the pending sources
    st_d.code = code_c;

    // read data valid only in the cycle after the read strobe
    st_d.rdata = CTS_DATA_ZERO;
    if (rd) begin
      unique case (addr)
        CTS_OVF_ADDR: begin
          st_d.rdata = {{(CTS_DATA_W-CTS_FIFO_N){1'b0}}, st_q.ovf};
        end
        CTS_TMR_ADDR: begin
          st_d.rdata = {st_q.count, st_q.prescale};
        end
        CTS_CTRL_ADDR: begin
          st_d.rdata[CTS_CTRL_CAP_BIT] = st_q.cap_en;
        end
        CTS_EVT_ADDR: begin
          st_d.rdata[CTS_EVT_TMR_BIT] = st_q.tmr_evt;
        end
        CTS_VEC_ADDR: begin
          st_d.rdata = {{(CTS_DATA_W-CTS_CODE_W){1'b0}}, st_q.code};
        end
        default: begin
          st_d.rdata = CTS_DATA_ZERO; // unmapped reads zero
        end
      endcase
    end

    // writes to the read-only overflow register are ignored
    if (wr_ovf) begin
      st_d.ovf = st_d.ovf;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= CTS_STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rdata = st_q.rdata;
  assign fifo_overflow_flags = st_q.ovf;
  assign timestamp_capture_enable = st_q.cap_en;
  assign timestamp_count = st_q.count;
  assign rx_overflow_event = |st_q.ovf;
  assign timestamp_timer_event = st_q.tmr_evt;
  assign interrupt_code_field = st_q.code;

endmodule : cts_top

/* File: rtl/cts_pkg.sv */
// package: register map, field layout, reset values and codes of the time stamp and overflow status block
package cts_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // bus and field widths
  localparam int unsigned CTS_ADDR_W = 8;
  localparam int unsigned CTS_DATA_W = 32;
  localparam int unsigned CTS_FIFO_N = 16;
  localparam int unsigned CTS_CNT_W = 16;
  localparam int unsigned CTS_CODE_W = 7;

  typedef logic [CTS_ADDR_W-1:0] cts_addr_t;
  typedef logic [CTS_DATA_W-1:0] cts_data_t;
  typedef logic [CTS_FIFO_N-1:0] cts_fifo_t;
  typedef logic [CTS_CNT_W-1:0] cts_cnt_t;
  typedef logic [CTS_CODE_W-1:0] cts_code_t;

  ////////////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam cts_addr_t CTS_OVF_ADDR = 8'h00;
  localparam cts_addr_t CTS_TMR_ADDR = 8'h04;
  localparam cts_addr_t CTS_CTRL_ADDR = 8'h08;
  localparam cts_addr_t CTS_EVT_ADDR = 8'h0C;
  localparam cts_addr_t CTS_VEC_ADDR = 8'h10;

  ////////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned CTS_TMR_COUNT_LSB = 16;
  localparam int unsigned CTS_TMR_PRE_LSB = 0;
  localparam int unsigned CTS_CTRL_CAP_BIT = 0;
  localparam int unsigned CTS_EVT_TMR_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values and constants
  localparam cts_cnt_t CTS_CNT_RST = 16'h0000;
  localparam cts_cnt_t CTS_CNT_ONE = 16'h0001;
  localparam cts_cnt_t CTS_CNT_MAX = 16'hFFFF;
  localparam cts_fifo_t CTS_OVF_RST = 16'h0000;
  localparam cts_data_t CTS_DATA_ZERO = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt source codes
  localparam cts_code_t CTS_CODE_NONE = 7'h40;
  localparam cts_code_t CTS_CODE_RX_OVF = 7'h43;
  localparam cts_code_t CTS_CODE_TMR = 7'h46;

endpackage : cts_pkg

/* File: rtl/cts_tick_if.sv */
// interface: prescaler control and tick between the top and the prescaler
interface cts_tick_if;
  import cts_pkg::*;
  cts_cnt_t prescale;
  logic enable;
  logic restart;
  logic tick;

  modport ctrl (output prescale, output enable, output restart, input tick);
  modport presc (input prescale, input enable, input restart, output tick);
endinterface : cts_tick_if

/* File: rtl/cts_prescaler.sv */
// prescaler: divides the system clock by the programmed prescale value
module cts_prescaler
  import cts_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  cts_tick_if.presc tk
);

  typedef struct packed {
    cts_cnt_t cnt;
  } cts_presc_st_t;

  cts_presc_st_t st_q;
  cts_presc_st_t st_d;
  logic last;

  ////////////////////////////////////////////////////////////////////////////////
  // period is max(prescale, 1): zero ticks every clock, all ones every 65535
  assign last = (tk.prescale == CTS_CNT_RST) || (st_q.cnt >= (tk.prescale - CTS_CNT_ONE));
  assign tk.tick = tk.enable && !tk.restart && last;

  // next state: restart on register write, hold while disabled
  always_comb begin
    st_d = st_q;
    if (tk.restart) begin
      st_d.cnt = CTS_CNT_RST;
    end else if (tk.enable) begin
      st_d.cnt = last ? CTS_CNT_RST : st_q.cnt + CTS_CNT_ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= '{cnt: CTS_CNT_RST};
    end else begin
      st_q <= st_d;
    end
  end

endmodule : cts_prescaler

/* File: rtl/cts_interrupt_code_field.sv */
// interrupt code encoder for the overflow and time stamp sources
module cts_interrupt_code_field
  import cts_pkg::*;
(
  input wire logic ovf_pending,
  input wire logic tmr_pending,
  output cts_code_t code
);

  ////////////////////////////////////////////////////////////////////////////////
  // overflow outranks the timer; nothing pending gives the idle code
  always_comb begin
    if (ovf_pending) begin
      code = CTS_CODE_RX_OVF;
    end else if (tmr_pending) begin
      code = CTS_CODE_TMR;
    end else begin
      code = CTS_CODE_NONE;
    end
  end

endmodule : cts_interrupt_code_field

/* File: tb/cts_top_monitor.sv */
// checker: port assertions of the time stamp and overflow status block
module cts_top_monitor
  import cts_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input cts_pkg::cts_addr_t addr,
  input wire logic wr,
  input wire logic rd,
  input cts_pkg::cts_data_t rdata,
  input cts_pkg::cts_fifo_t fifo_overflow_set,
  input cts_pkg::cts_fifo_t fifo_overflow_clear,
  input cts_pkg::cts_fifo_t fifo_overflow_flags,
  input wire logic timestamp_capture_enable,
  input cts_pkg::cts_cnt_t timestamp_count,
  input wire logic rx_overflow_event,
  input wire logic timestamp_timer_event,
  input cts_pkg::cts_code_t interrupt_code_field
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // a timer write may load any count
  logic tmr_wr;
  assign tmr_wr = wr && addr == CTS_TMR_ADDR;
  ////////////////////////////////////////
  // flags, overflow interrupt code and read path
  a_flag_update: assert property (
    fifo_overflow_flags == (($past(fifo_overflow_flags) & ~$past(fifo_overflow_clear)) | $past(fifo_overflow_set)))
    else $error("overflow flags wrong");
  a_ovf_event: assert property (rx_overflow_event == |fifo_overflow_flags)
    else $error("overflow event wrong");
  a_code_ovf: assert property (rx_overflow_event |=> interrupt_code_field == CTS_CODE_RX_OVF)
    else $error("overflow code wrong");
  a_ovf_read: assert property (
    rd && addr == CTS_OVF_ADDR |=> rdata == {16'h0000, $past(fifo_overflow_flags)})
    else $error("overflow read wrong");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == '0)
    else $error("read data not idle");
  // timer count, wrap and timer interrupt code
  a_cnt_hold: assert property (
    !timestamp_capture_enable && !$past(timestamp_capture_enable) && !tmr_wr |=> $stable(timestamp_count))
    else $error("count moved while paused");
  a_cnt_step: assert property (
    $changed(timestamp_count) && !$past(tmr_wr) |-> timestamp_count == $past(timestamp_count) + 16'h0001)
    else $error("count step wrong");
  a_wrap_event: assert property (
    $past(timestamp_count) == 16'hFFFF && timestamp_count == '0 && !$past(tmr_wr) |-> timestamp_timer_event)
    else $error("wrap event missing");
  a_code_tmr: assert property (
    !rx_overflow_event && timestamp_timer_event |=> interrupt_code_field == CTS_CODE_TMR)
    else $error("timer code wrong");
endmodule : cts_top_monitor

bind cts_top cts_top_monitor u_mon (.clock(clock), .rst(rst), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata),
  .fifo_overflow_set(fifo_overflow_set), .fifo_overflow_clear(fifo_overflow_clear),
  .fifo_overflow_flags(fifo_overflow_flags), .timestamp_capture_enable(timestamp_capture_enable),
  .timestamp_count(timestamp_count), .rx_overflow_event(rx_overflow_event),
  .timestamp_timer_event(timestamp_timer_event), .interrupt_code_field(interrupt_code_field));

/* File: tb/testbench.sv */
// testbench: self-checking bench of the time stamp and overflow status block
module testbench
  import cts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, cap, ovf_ev, tmr_ev;
  cts_addr_t addr = '0;
  cts_data_t wdata = '0, rdata;
  cts_fifo_t ovf_set = '0, ovf_clr = '0, flags;
  cts_cnt_t cnt;
  cts_code_t code;
  int miscompares = 0, n_tests = 0, p, c, m;
  int md_flags = 0, md_cnt = 0, md_pre = 0, md_div = 0, md_cap = 0, md_evt = 0, md_code = 0, md_rd = 0;
  int md_rdq[$];
  logic md_tick = 1'b0;
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
  // clock and design
  initial forever #2.5 clock = ~clock;
  cts_top dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .fifo_overflow_set(ovf_set), .fifo_overflow_clear(ovf_clr), .fifo_overflow_flags(flags),
    .timestamp_capture_enable(cap), .timestamp_count(cnt), .rx_overflow_event(ovf_ev),
    .timestamp_timer_event(tmr_ev), .interrupt_code_field(code));
  ////////////////////////////////////////
  // reference model: integers from the rules, stepped on every rising edge
  always @(posedge clock) begin
    if (rst) begin
      md_flags = 0;
      md_cnt = 0;
      md_pre = 0;
      md_div = 0;
      md_cap = 0;
      md_evt = 0;
      md_code = CTS_CODE_NONE;
      md_rdq.delete();
    end else begin
      // read answers come from the state before this edge
      if (rd) begin
        case (addr)
          CTS_OVF_ADDR: md_rdq.push_back(md_flags);
          CTS_TMR_ADDR: md_rdq.push_back((md_cnt << 16) | md_pre);
          CTS_CTRL_ADDR: md_rdq.push_back(md_cap);
          CTS_EVT_ADDR: md_rdq.push_back(md_evt);
          CTS_VEC_ADDR: md_rdq.push_back(md_code);
          default: md_rdq.push_back(0);
        endcase
      end
      // the code register follows the sources pending before this edge
      md_code = (md_flags != 0) ? CTS_CODE_RX_OVF : ((md_evt != 0) ? CTS_CODE_TMR : CTS_CODE_NONE);
      // prescaler: period of max(prescale, 1) clocks, restarted by a timer write
      md_tick = 1'b0;
      if (wr && addr == CTS_TMR_ADDR) begin
        md_div = 0;
      end else if (md_cap != 0) begin
        md_div++;
        if (md_div >= ((md_pre > 1) ? md_pre : 1)) begin
          md_div = 0;
          md_tick = 1'b1;
        end
      end
      if (wr && addr == CTS_EVT_ADDR && wdata[CTS_EVT_TMR_BIT]) begin
        md_evt = 0;
      end
      if (md_tick && md_cnt == 65535) begin
        md_evt = 1;
      end
      if (wr && addr == CTS_TMR_ADDR) begin
        md_cnt = wdata[31:16];
        md_pre = wdata[15:0];
      end else if (md_tick) begin
        md_cnt = (md_cnt + 1) % 65536;
      end
      if (wr && addr == CTS_CTRL_ADDR) begin
        md_cap = wdata[CTS_CTRL_CAP_BIT];
      end
      md_flags = (md_flags & ~ovf_clr) | ovf_set;
    end
  end
  // the model meets the design halfway through every cycle
  always @(negedge clock) begin
    if (!rst) begin
      md_rd = (md_rdq.size() > 0) ? md_rdq.pop_front() : 0;
      `CHK("model rdata", md_rd, rdata)
      `CHK("model flags", md_flags, flags)
      `CHK("model ovf event", md_flags != 0, ovf_ev)
      `CHK("model count", md_cnt, cnt)
      `CHK("model capture", md_cap, cap)
      `CHK("model timer event", md_evt, tmr_ev)
      `CHK("model code", md_code, code)
    end
  end
  ////////////////////////////////////////
  // bus cycles and waits
  task automatic wr_reg(input cts_addr_t a, input cts_data_t d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input cts_addr_t a, input cts_data_t e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 `CHK("rdata", e, rdata)
  endtask : rd_chk
  task automatic clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : clk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  // watchdog
  initial begin
    repeat (90000) @(posedge clock);
    miscompares++;
    finish_test();
  end
  // main sequence
  initial begin
    void'($urandom(32'h49827EBD));
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rd_chk(CTS_TMR_ADDR, '0);
    rd_chk(CTS_VEC_ADDR, 32'h0000_0040);
    rd_chk(8'h14, '0);
    wr_reg(CTS_OVF_ADDR, 32'hFFFF_FFFF);
    rd_chk(CTS_OVF_ADDR, '0);
    $display("test reset done");
    m = 0;
    for (int n = 0; n < 16; n++) begin
      @(posedge clock);
      ovf_set <= 16'h0001 << n;
      m = m | (1 << n);
      @(posedge clock);
      ovf_set <= '0;
      #1 `CHK("flags", m[15:0], flags)
    end
    rd_chk(CTS_OVF_ADDR, 32'h0000_FFFF);
    rd_chk(CTS_VEC_ADDR, 32'h0000_0043);
    c = $urandom;
    @(posedge clock);
    ovf_clr <= c[15:0];
    clk(1);
    `CHK("flags", ~c[15:0], flags)
    @(posedge clock);
    ovf_clr <= 16'hFFFF;
    clk(1);
    `CHK("ovf event", 1'b0, ovf_ev)
    @(posedge clock);
    ovf_clr <= '0;
    $display("test overflow done");
    c = $urandom;
    wr_reg(CTS_TMR_ADDR, c);
    clk(20);
    `CHK("count", c[31:16], cnt)
    rd_chk(CTS_TMR_ADDR, c);
    wr_reg(CTS_TMR_ADDR, 32'hFFFE_0000);
    wr_reg(CTS_CTRL_ADDR, 32'h0000_0001);
    clk(1);
    `CHK("count", 16'hFFFF, cnt)
    clk(1);
    `CHK("timer event", 1'b1, tmr_ev)
    clk(1);
    `CHK("code", CTS_CODE_TMR, code)
    rd_chk(CTS_CTRL_ADDR, 32'h0000_0001);
    rd_chk(CTS_EVT_ADDR, 32'h0000_0001);
    wr_reg(CTS_EVT_ADDR, 32'h0000_0001);
    rd_chk(CTS_EVT_ADDR, '0);
    $display("test wrap done");
    p = 3 + $urandom % 6;
    c = $urandom % 32'h0000_FF00;
    for (int k = 0; k < 2; k++) begin
      wr_reg(CTS_TMR_ADDR, {c[15:0], p[15:0]});
      clk(p - 1);
      `CHK("count", c[15:0], cnt)
      clk(1);
      `CHK("count", c[15:0] + 16'h0001, cnt)
    end
    $display("test prescale done");
    wr_reg(CTS_TMR_ADDR, 32'h0005_FFFF);
    clk(65534);
    `CHK("count", 16'h0005, cnt)
    clk(1);
    `CHK("count", 16'h0006, cnt)
    $display("test long prescale done");
    finish_test();
  end
endmodule : testbench
